// File: core/charger_limit_regs.svh
// Offsets, field positions, reset values and clamp limits of the limit bank
`ifndef CHARGER_LIMIT_REGS_SVH
`define CHARGER_LIMIT_REGS_SVH

// ----------------------------------------------------------------------
// Word offsets (even byte = bits 7:0, odd byte = bits 15:8)
// ----------------------------------------------------------------------
`define OFS_CHARGE_VOLTAGE_TARGET       8'h00
`define OFS_CHARGE_CURRENT_LIMIT        8'h02
`define OFS_INPUT_CURRENT_LIMIT         8'h06
`define OFS_INPUT_VOLTAGE_LIMIT         8'h08
`define OFS_REVERSE_INPUT_CURRENT_LIMIT 8'h0A
`define OFS_REVERSE_INPUT_VOLTAGE_LIMIT 8'h0C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FB_MSB    4
`define FB_LSB    0
`define CUR_MSB   10
`define CUR_LSB   2
`define VOLT_MSB  13
`define VOLT_LSB  2

// ----------------------------------------------------------------------
// Reset words
// ----------------------------------------------------------------------
`define RST_CHARGE_VOLTAGE_TARGET       16'h0010
`define RST_CHARGE_CURRENT_LIMIT        16'h0640
`define RST_INPUT_CURRENT_LIMIT         16'h0640
`define RST_INPUT_VOLTAGE_LIMIT         16'h0348
`define RST_REVERSE_INPUT_CURRENT_LIMIT 16'h0640
`define RST_REVERSE_INPUT_VOLTAGE_LIMIT 16'h03E8

// ----------------------------------------------------------------------
// Clamp limits in field codes
// ----------------------------------------------------------------------
`define CUR_CODE_MIN   9'h008
`define CUR_CODE_MAX   9'h190
`define VIN_CODE_MIN   12'h0DC
`define VREV_CODE_MIN  12'h0A5
`define VOLT_CODE_MAX  12'hCB2

// ----------------------------------------------------------------------
// Serial interface
// ----------------------------------------------------------------------
`define BITS_PER_BYTE  4'h8
`define DEV_ADDR_RST   7'h2A

`endif

// File: core/charger_limit_pkg.sv
// Types shared by the limit bank modules
package charger_limit_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_ACK_ADR = 3'b010,
    ST_RX      = 3'b011,
    ST_ACK_RX  = 3'b100,
    ST_TX      = 3'b101,
    ST_ACK_TX  = 3'b110
  } serial_state_e;

  typedef struct packed {
    logic          scl_s1;
    logic          scl_s2;
    logic          scl_d;
    logic          sda_s1;
    logic          sda_s2;
    logic          sda_d;
    serial_state_e state;
    logic [3:0]    bit_cnt;
    logic [7:0]    shreg;
    logic [7:0]    ptr;
    logic          ptr_phase;
    logic          rd_mode;
    logic          host_ack;
    logic          sda_oe;
    logic          sda_out;
    logic          wr_en;
    logic [8:0]    eff_charge;
    logic [8:0]    eff_input;
  } serial_s;

  typedef struct packed {
    logic [4:0]  fb;
    logic [8:0]  chg;
    logic [8:0]  inc;
    logic [11:0] inv;
    logic [8:0]  rev_i;
    logic [11:0] rev_v;
    logic [7:0]  rd_data;
  } bank_s;

endpackage : charger_limit_pkg

// File: core/limit_bus_if.sv
// Byte access path and field taps between serial front end and bank
`timescale 1ns/10ps
interface limit_bus_if;
  logic        wr_en;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [4:0]  fb;
  logic [8:0]  chg;
  logic [8:0]  inc;
  logic [11:0] inv;
  logic [8:0]  rev_i;
  logic [11:0] rev_v;

  modport master (output wr_en, addr, wdata,
                  input  rdata, fb, chg, inc, inv, rev_i, rev_v);
  modport bank   (input  wr_en, addr, wdata,
                  output rdata, fb, chg, inc, inv, rev_i, rev_v);
endinterface : limit_bus_if

// File: core/limit_reg_file.sv
// Six limit registers with byte writes, clamping and registered read data
`timescale 1ns/10ps
`include "charger_limit_regs.svh"
module limit_reg_file (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic reg_reset,
  input  wire logic wdog_expire,
  limit_bus_if.bank bus
);

  charger_limit_pkg::bank_s cur_ff;
  charger_limit_pkg::bank_s nxt_cur;

  function automatic logic [8:0] clamp_cur(input logic [8:0] v);
    if (v < `CUR_CODE_MIN) return `CUR_CODE_MIN;
    if (v > `CUR_CODE_MAX) return `CUR_CODE_MAX;
    return v;
  endfunction : clamp_cur

  function automatic logic [11:0] clamp_volt(input logic [11:0] v,
                                             input logic [11:0] lo);
    if (v < lo) return lo;
    if (v > `VOLT_CODE_MAX) return `VOLT_CODE_MAX;
    return v;
  endfunction : clamp_volt

  // Reserved bits are rebuilt as zero on every read
  function automatic logic [15:0] word_of(input charger_limit_pkg::bank_s b,
                                          input logic [7:0] ofs);
    logic [15:0] w;
    w = 16'h0000;
    unique case (ofs)
      `OFS_CHARGE_VOLTAGE_TARGET:       w[`FB_MSB:`FB_LSB] = b.fb;
      `OFS_CHARGE_CURRENT_LIMIT:        w[`CUR_MSB:`CUR_LSB] = b.chg;
      `OFS_INPUT_CURRENT_LIMIT:         w[`CUR_MSB:`CUR_LSB] = b.inc;
      `OFS_INPUT_VOLTAGE_LIMIT:         w[`VOLT_MSB:`VOLT_LSB] = b.inv;
      `OFS_REVERSE_INPUT_CURRENT_LIMIT: w[`CUR_MSB:`CUR_LSB] = b.rev_i;
      `OFS_REVERSE_INPUT_VOLTAGE_LIMIT: w[`VOLT_MSB:`VOLT_LSB] = b.rev_v;
      default:                          w = 16'h0000;
    endcase
    return w;
  endfunction : word_of

  localparam logic [15:0] RW_FB  = `RST_CHARGE_VOLTAGE_TARGET;
  localparam logic [15:0] RW_CHG = `RST_CHARGE_CURRENT_LIMIT;
  localparam logic [15:0] RW_INC = `RST_INPUT_CURRENT_LIMIT;
  localparam logic [15:0] RW_INV = `RST_INPUT_VOLTAGE_LIMIT;
  localparam logic [15:0] RW_RVI = `RST_REVERSE_INPUT_CURRENT_LIMIT;
  localparam logic [15:0] RW_RVV = `RST_REVERSE_INPUT_VOLTAGE_LIMIT;

  always_comb begin
    logic [7:0]  base;
    logic [15:0] w;
    base = {bus.addr[7:1], 1'b0};
    w = word_of(cur_ff, base);
    if (bus.addr[0]) begin
      w[15:8] = bus.wdata;
    end else begin
      w[7:0] = bus.wdata;
    end
    nxt_cur = cur_ff;
    if (bus.wr_en) begin
      unique case (base)
        `OFS_CHARGE_VOLTAGE_TARGET:       nxt_cur.fb = w[`FB_MSB:`FB_LSB];
        `OFS_CHARGE_CURRENT_LIMIT:
          nxt_cur.chg = clamp_cur(w[`CUR_MSB:`CUR_LSB]);
        `OFS_INPUT_CURRENT_LIMIT:
          nxt_cur.inc = clamp_cur(w[`CUR_MSB:`CUR_LSB]);
        `OFS_INPUT_VOLTAGE_LIMIT:
          nxt_cur.inv = clamp_volt(w[`VOLT_MSB:`VOLT_LSB], `VIN_CODE_MIN);
        `OFS_REVERSE_INPUT_CURRENT_LIMIT:
          nxt_cur.rev_i = clamp_cur(w[`CUR_MSB:`CUR_LSB]);
        `OFS_REVERSE_INPUT_VOLTAGE_LIMIT:
          nxt_cur.rev_v = clamp_volt(w[`VOLT_MSB:`VOLT_LSB], `VREV_CODE_MIN);
        default: nxt_cur.rd_data = cur_ff.rd_data;
      endcase
    end
    if (wdog_expire) begin
      nxt_cur.chg = RW_CHG[`CUR_MSB:`CUR_LSB];
    end
    if (reg_reset) begin
      nxt_cur.fb    = RW_FB[`FB_MSB:`FB_LSB];
      nxt_cur.chg   = RW_CHG[`CUR_MSB:`CUR_LSB];
      nxt_cur.inc   = RW_INC[`CUR_MSB:`CUR_LSB];
      nxt_cur.inv   = RW_INV[`VOLT_MSB:`VOLT_LSB];
      nxt_cur.rev_i = RW_RVI[`CUR_MSB:`CUR_LSB];
      nxt_cur.rev_v = RW_RVV[`VOLT_MSB:`VOLT_LSB];
    end
    w = word_of(cur_ff, base);
    nxt_cur.rd_data = bus.addr[0] ? w[15:8] : w[7:0];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '{fb: RW_FB[`FB_MSB:`FB_LSB],
                  chg: RW_CHG[`CUR_MSB:`CUR_LSB],
                  inc: RW_INC[`CUR_MSB:`CUR_LSB],
                  inv: RW_INV[`VOLT_MSB:`VOLT_LSB],
                  rev_i: RW_RVI[`CUR_MSB:`CUR_LSB],
                  rev_v: RW_RVV[`VOLT_MSB:`VOLT_LSB],
                  rd_data: 8'h00};
    end else if (ce) begin
      cur_ff <= nxt_cur;
    end
  end

  assign bus.rdata = cur_ff.rd_data;
  assign bus.fb    = cur_ff.fb;
  assign bus.chg   = cur_ff.chg;
  assign bus.inc   = cur_ff.inc;
  assign bus.inv   = cur_ff.inv;
  assign bus.rev_i = cur_ff.rev_i;
  assign bus.rev_v = cur_ff.rev_v;

endmodule : limit_reg_file

// File: core/charger_limit_register_bank.sv
// Limit register bank of the charge controller behind its serial port
//
// How it works
// - Each 16-bit register spans two bytes: even address low, odd high.
// - Feedback target in bits 4:0, resets to 10h, 2 mV steps from 1504.
// - Charge current in bits 10:2, resets 190h; watchdog also restores it.
// - Charge current limit is the lower of field and pin setting.
// - Current fields clamp writes to codes 8h through 190h.
// - Input current in bits 10:2; effective limit is lower of field, pin.
// - Input voltage in bits 13:2, 20 mV steps, clamped to DCh..CB2h.
// - Input voltage register resets to word 0348h, code D2h.
// - Reverse current in bits 10:2, resets 190h, 50 mA steps.
// - Reverse voltage in bits 13:2, resets FAh, clamped to A5h..CB2h.
`timescale 1ns/10ps
`include "charger_limit_regs.svh"
module charger_limit_register_bank #(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_RST
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        reg_reset,
  input  wire logic        wdog_expire,
  input  wire logic [8:0]  charge_current_pin,
  input  wire logic [8:0]  input_limit_pin,
  output logic [4:0]       fb_voltage_target,
  output logic [8:0]       charge_current_field,
  output logic [8:0]       input_current_field,
  output logic [11:0]      input_voltage_field,
  output logic [8:0]       reverse_current_field,
  output logic [11:0]      reverse_voltage_field,
  output logic [8:0]       charge_current_limit_eff,
  output logic [8:0]       input_current_limit_eff
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  charger_limit_pkg::serial_s cur_ff;
  charger_limit_pkg::serial_s nxt_cur;

  limit_bus_if bus ();

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // Edges come only from the second synchroniser stage and its delay
  assign scl_rise   = cur_ff.scl_s2 & ~cur_ff.scl_d;
  assign scl_fall   = ~cur_ff.scl_s2 & cur_ff.scl_d;
  assign start_seen = cur_ff.scl_s2 & cur_ff.scl_d &
                      cur_ff.sda_d & ~cur_ff.sda_s2;
  assign stop_seen  = cur_ff.scl_s2 & cur_ff.scl_d &
                      ~cur_ff.sda_d & cur_ff.sda_s2;

  // --------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------
  limit_reg_file u_file (
    .clk         (clk),
    .rst         (rst),
    .ce          (ce),
    .reg_reset   (reg_reset),
    .wdog_expire (wdog_expire),
    .bus         (bus)
  );

  assign bus.wr_en = cur_ff.wr_en;
  assign bus.addr  = cur_ff.ptr;
  assign bus.wdata = cur_ff.shreg;

  // --------------------------------------------------------------------
  // Serial slave and effective limits
  // --------------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.scl_s1 = scl_in;
    nxt_cur.scl_s2 = cur_ff.scl_s1;
    nxt_cur.scl_d  = cur_ff.scl_s2;
    nxt_cur.sda_s1 = sda_in;
    nxt_cur.sda_s2 = cur_ff.sda_s1;
    nxt_cur.sda_d  = cur_ff.sda_s2;
    nxt_cur.wr_en  = 1'b0;
    nxt_cur.sda_out = 1'b0;

    // Pin codes come from the pin decoder on this clock
    nxt_cur.eff_charge = (bus.chg < charge_current_pin) ?
                         bus.chg : charge_current_pin;
    nxt_cur.eff_input  = (bus.inc < input_limit_pin) ?
                         bus.inc : input_limit_pin;

    if (start_seen) begin
      // Repeated start keeps the pointer so a read can follow a write
      nxt_cur.state     = charger_limit_pkg::ST_ADDR;
      nxt_cur.bit_cnt   = 4'h0;
      nxt_cur.sda_oe    = 1'b0;
      nxt_cur.ptr_phase = 1'b1;
    end else if (stop_seen) begin
      nxt_cur.state  = charger_limit_pkg::ST_IDLE;
      nxt_cur.sda_oe = 1'b0;
    end else begin
      unique case (cur_ff.state)
        charger_limit_pkg::ST_IDLE: begin
          nxt_cur.sda_oe = 1'b0;
        end

        charger_limit_pkg::ST_ADDR: begin
          if (scl_rise) begin
            nxt_cur.shreg   = {cur_ff.shreg[6:0], cur_ff.sda_s2};
            nxt_cur.bit_cnt = cur_ff.bit_cnt + 4'h1;
          end else if (scl_fall && cur_ff.bit_cnt == `BITS_PER_BYTE) begin
            if (cur_ff.shreg[7:1] == DEV_ADDR) begin
              nxt_cur.state   = charger_limit_pkg::ST_ACK_ADR;
              nxt_cur.rd_mode = cur_ff.shreg[0];
              nxt_cur.sda_oe  = 1'b1;
            end else begin
              // Another target is addressed; wait for the next start
              nxt_cur.state = charger_limit_pkg::ST_IDLE;
            end
          end
        end

        charger_limit_pkg::ST_ACK_ADR: begin
          if (scl_fall) begin
            nxt_cur.bit_cnt = 4'h0;
            if (cur_ff.rd_mode) begin
              nxt_cur.state  = charger_limit_pkg::ST_TX;
              nxt_cur.shreg  = bus.rdata;
              nxt_cur.sda_oe = ~bus.rdata[7];
            end else begin
              nxt_cur.state  = charger_limit_pkg::ST_RX;
              nxt_cur.sda_oe = 1'b0;
            end
          end
        end

        charger_limit_pkg::ST_RX: begin
          if (scl_rise) begin
            nxt_cur.shreg   = {cur_ff.shreg[6:0], cur_ff.sda_s2};
            nxt_cur.bit_cnt = cur_ff.bit_cnt + 4'h1;
          end else if (scl_fall && cur_ff.bit_cnt == `BITS_PER_BYTE) begin
            nxt_cur.state  = charger_limit_pkg::ST_ACK_RX;
            nxt_cur.sda_oe = 1'b1;
            if (cur_ff.ptr_phase) begin
              nxt_cur.ptr = cur_ff.shreg;
            end else begin
              nxt_cur.wr_en = 1'b1;
            end
          end
        end

        charger_limit_pkg::ST_ACK_RX: begin
          if (scl_fall) begin
            // Advance only after the write pulse used the old pointer
            if (!cur_ff.ptr_phase) begin
              nxt_cur.ptr = cur_ff.ptr + 8'h01;
            end
            nxt_cur.ptr_phase = 1'b0;
            nxt_cur.state     = charger_limit_pkg::ST_RX;
            nxt_cur.bit_cnt   = 4'h0;
            nxt_cur.sda_oe    = 1'b0;
          end
        end

        charger_limit_pkg::ST_TX: begin
          if (scl_fall) begin
            nxt_cur.bit_cnt = cur_ff.bit_cnt + 4'h1;
            if (cur_ff.bit_cnt == `BITS_PER_BYTE - 4'h1) begin
              nxt_cur.state  = charger_limit_pkg::ST_ACK_TX;
              nxt_cur.sda_oe = 1'b0;
              nxt_cur.ptr    = cur_ff.ptr + 8'h01;
            end else begin
              nxt_cur.shreg  = {cur_ff.shreg[6:0], 1'b0};
              nxt_cur.sda_oe = ~cur_ff.shreg[6];
            end
          end
        end

        charger_limit_pkg::ST_ACK_TX: begin
          if (scl_rise) begin
            nxt_cur.host_ack = ~cur_ff.sda_s2;
          end else if (scl_fall) begin
            nxt_cur.bit_cnt = 4'h0;
            if (cur_ff.host_ack) begin
              // Read data follows the pointer advanced a byte earlier
              nxt_cur.state  = charger_limit_pkg::ST_TX;
              nxt_cur.shreg  = bus.rdata;
              nxt_cur.sda_oe = ~bus.rdata[7];
            end else begin
              nxt_cur.state = charger_limit_pkg::ST_IDLE;
            end
          end
        end

        default: begin
          nxt_cur.state  = charger_limit_pkg::ST_IDLE;
          nxt_cur.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
                  sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
                  state: charger_limit_pkg::ST_IDLE,
                  bit_cnt: 4'h0, shreg: 8'h00, ptr: 8'h00,
                  ptr_phase: 1'b0, rd_mode: 1'b0, host_ack: 1'b0,
                  sda_oe: 1'b0, sda_out: 1'b0, wr_en: 1'b0,
                  eff_charge: `CUR_CODE_MAX, eff_input: `CUR_CODE_MAX};
    end else if (ce) begin
      cur_ff <= nxt_cur;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign sda_out                  = cur_ff.sda_out;
  assign sda_oe                   = cur_ff.sda_oe;
  assign fb_voltage_target        = bus.fb;
  assign charge_current_field     = bus.chg;
  assign input_current_field      = bus.inc;
  assign input_voltage_field      = bus.inv;
  assign reverse_current_field    = bus.rev_i;
  assign reverse_voltage_field    = bus.rev_v;
  assign charge_current_limit_eff = cur_ff.eff_charge;
  assign input_current_limit_eff  = cur_ff.eff_input;

endmodule : charger_limit_register_bank

// File: test/charger_limit_props.sv
// Concurrent checks on the ports of the limit register bank
`timescale 1ns/10ps
module charger_limit_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        reg_reset,
  input wire logic        wdog_expire,
  input wire logic [8:0]  charge_current_pin,
  input wire logic [8:0]  input_limit_pin,
  input wire logic [4:0]  fb_voltage_target,
  input wire logic [8:0]  charge_current_field,
  input wire logic [8:0]  input_current_field,
  input wire logic [11:0] input_voltage_field,
  input wire logic [8:0]  reverse_current_field,
  input wire logic [11:0] reverse_voltage_field,
  input wire logic [8:0]  charge_current_limit_eff,
  input wire logic [8:0]  input_current_limit_eff
);
  // --------------------------------------------------------------------
  // Field and effective limit checks
  // --------------------------------------------------------------------
  logic [8:0] chg_min;
  logic [8:0] inp_min;
  assign chg_min = charge_current_field < charge_current_pin ?
                   charge_current_field : charge_current_pin;
  assign inp_min = input_current_field < input_limit_pin ?
                   input_current_field : input_limit_pin;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence clear_s;
    fb_voltage_target == 5'h10 && charge_current_field == 9'h190 &&
    input_current_field == 9'h190 && input_voltage_field == 12'h0D2 &&
    reverse_current_field == 9'h190 && reverse_voltage_field == 12'h0FA;
  endsequence
  sequence restore_cmd_s;
    ce && reg_reset;
  endsequence
  reset_codes_a:
    assert property ($fell(rst) |-> clear_s)
    else $error("field off its reset code after reset");
  cmd_restore_a:
    assert property (restore_cmd_s |=> clear_s)
    else $error("register reset left a field changed");
  wdog_restore_a:
    assert property (ce && wdog_expire |=> charge_current_field == 9'h190)
    else $error("watchdog did not restore charge current");
  chg_eff_a:
    assert property (ce |=> charge_current_limit_eff == $past(chg_min))
    else $error("charge limit is not the lower setting");
  inp_eff_a:
    assert property (ce |=> input_current_limit_eff == $past(inp_min))
    else $error("input limit is not the lower setting");
  cur_clamp_a:
    assert property (charge_current_field inside {[9'h008:9'h190]} &&
      input_current_field inside {[9'h008:9'h190]} &&
      reverse_current_field inside {[9'h008:9'h190]})
    else $error("current field outside its clamp range");
  vin_clamp_a:
    assert property (input_voltage_field inside {12'h0D2, [12'h0DC:12'hCB2]})
    else $error("input voltage field outside its range");
  vrev_clamp_a:
    assert property (reverse_voltage_field inside {[12'h0A5:12'hCB2]})
    else $error("reverse voltage field outside its range");
endmodule : charger_limit_props

// File: test/serial_host_model.sv
// Behavioural serial host driving the bank's bus pins
`timescale 1ns/10ps
module serial_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // Half bit period in clocks; raised by the bench for a slow host
  int unsigned ph = 8;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick();
    repeat (ph) @(posedge clk);
    #1;
  endtask : tick
  // Also serves as repeated start when entered with SCL low
  task automatic start_c();
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b1;
    tick();
    scl = 1'b0;
  endtask : start_c
  task automatic stop_c();
    sda_low = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b0;
    tick();
  endtask : stop_c
  // Eight data bits then the acknowledge slot, msb first
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_low = ~d[i];
      tick();
      scl = 1'b1;
      tick();
      q[i] = sda;
      scl = 1'b0;
      // Data moves two clocks after SCL falls so no false START/STOP
      repeat (2) @(posedge clk);
      #1;
    end
  endtask : xfer
endmodule : serial_host_model

// File: test/charger_limit_register_bank_tb.sv
// Self-checking bench for the charger limit register bank
`timescale 1ns/10ps
`include "charger_limit_regs.svh"
module charger_limit_register_bank_tb;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic        reg_reset = 1'b0, wdog_expire = 1'b0;
  logic [8:0]  chg_pin = 9'h1FF, inl_pin = 9'h1FF;
  logic        scl, sda_low, sda_out, sda_oe;
  logic [4:0]  fb;
  logic [8:0]  chg, inc, rev_i, chg_eff, inc_eff;
  logic [11:0] inv, rev_v;
  logic [15:0] rd_w;
  int          error_cnt = 0, total_checks = 0, cyc = 0;
  // Pull-up wins unless a party pulls low
  wire         sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
  // Offset, reset word, word after FFFFh, word after 0000h
  logic [15:0] tbl [6][4] = '{
    '{16'h0000, 16'h0010, 16'h001F, 16'h0000},
    '{16'h0002, 16'h0640, 16'h0640, 16'h0020},
    '{16'h0006, 16'h0640, 16'h0640, 16'h0020},
    '{16'h0008, 16'h0348, 16'h32C8, 16'h0370},
    '{16'h000A, 16'h0640, 16'h0640, 16'h0020},
    '{16'h000C, 16'h03E8, 16'h32C8, 16'h0294}};
  always #2.5 clk = ~clk;
  charger_limit_register_bank uut (
    .clk(clk), .rst(rst), .ce(ce), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .reg_reset(reg_reset),
    .wdog_expire(wdog_expire), .charge_current_pin(chg_pin),
    .input_limit_pin(inl_pin), .fb_voltage_target(fb),
    .charge_current_field(chg), .input_current_field(inc),
    .input_voltage_field(inv), .reverse_current_field(rev_i),
    .reverse_voltage_field(rev_v), .charge_current_limit_eff(chg_eff),
    .input_current_limit_eff(inc_eff));
  serial_host_model u_host (.clk(clk), .sda(sda), .scl(scl),
                            .sda_low(sda_low));
  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [15:0] w, input int n);
    logic [8:0] q;
    u_host.start_c();
    u_host.xfer({`DEV_ADDR_RST, 1'b0, 1'b1}, q);
    check(q[0], 1'b0);
    u_host.xfer({a, 1'b1}, q);
    for (int i = 0; i < n; i++) begin
      u_host.xfer({w[8*i +: 8], 1'b1}, q);
    end
    u_host.stop_c();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] w);
    logic [8:0] q;
    u_host.start_c();
    u_host.xfer({`DEV_ADDR_RST, 1'b0, 1'b1}, q);
    u_host.xfer({a, 1'b1}, q);
    u_host.start_c();
    u_host.xfer({`DEV_ADDR_RST, 1'b1, 1'b1}, q);
    u_host.xfer(9'h1FE, q);
    w[7:0] = q[8:1];
    u_host.xfer(9'h1FF, q);
    w[15:8] = q[8:1];
    u_host.stop_c();
  endtask : rd
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk);
    #1;
    s = 1'b0;
  endtask : pulse
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic reset_scn();
    for (int i = 0; i < 6; i++) begin
      rd(tbl[i][0][7:0], rd_w);
      check(rd_w, tbl[i][1]);
    end
    check(chg_eff, 9'h190);
  endtask : reset_scn
  task automatic clamp_scn();
    for (int i = 0; i < 6; i++) begin
      wr(tbl[i][0][7:0], 16'hFFFF, 2);
      rd(tbl[i][0][7:0], rd_w);
      check(rd_w, tbl[i][2]);
      wr(tbl[i][0][7:0], 16'h0000, 2);
      rd(tbl[i][0][7:0], rd_w);
      check(rd_w, tbl[i][3]);
    end
    check(inv, 12'h0DC);
    wr(8'h04, 16'hFFFF, 2);
    rd(8'h04, rd_w);
    check(rd_w, 16'h0000);
    // Low byte 34h lands alone first and clamps to DCh before 12h merges
    wr(8'h08, 16'h1234, 2);
    rd(8'h08, rd_w);
    check(rd_w, 16'h1270);
    check(inv, 12'h49C);
  endtask : clamp_scn
  task automatic restore_scn();
    wr(8'h02, 16'h0100, 2);
    wr(8'h06, 16'h0100, 2);
    // Low byte first: field sits at 8h, so the word merges to 0120h
    check(chg, 9'h048);
    ce = 1'b0;
    pulse(wdog_expire);
    check(chg, 9'h048);
    ce = 1'b1;
    pulse(wdog_expire);
    check(chg, 9'h190);
    check(inc, 9'h048);
    pulse(reg_reset);
    check({fb, chg, inc[1:0]}, {5'h10, 9'h190, 2'h0});
    check(inc, 9'h190);
    check(inv, 12'h0D2);
    check(rev_i, 9'h190);
    check(rev_v, 12'h0FA);
  endtask : restore_scn
  task automatic eff_scn();
    wr(8'h02, 16'h0100, 2);
    chg_pin = 9'h050;
    inl_pin = 9'h0A0;
    @(posedge clk);
    #1;
    check(chg_eff, 9'h040);
    check(inc_eff, 9'h0A0);
    chg_pin = 9'h010;
    inl_pin = 9'h1FF;
    @(posedge clk);
    #1;
    check(chg_eff, 9'h010);
    check(inc_eff, 9'h190);
    // A slow host must read the same word
    u_host.ph = 30;
    rd(8'h02, rd_w);
    check(rd_w, 16'h0100);
    u_host.ph = 8;
  endtask : eff_scn
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    reset_scn();
    clamp_scn();
    restore_scn();
    eff_scn();
    end_of_test();
  end
endmodule : charger_limit_register_bank_tb
bind charger_limit_register_bank charger_limit_props u_props (
  .clk(clk), .rst(rst), .ce(ce), .reg_reset(reg_reset),
  .wdog_expire(wdog_expire), .charge_current_pin(charge_current_pin),
  .input_limit_pin(input_limit_pin), .fb_voltage_target(fb_voltage_target),
  .charge_current_field(charge_current_field),
  .input_current_field(input_current_field),
  .input_voltage_field(input_voltage_field),
  .reverse_current_field(reverse_current_field),
  .reverse_voltage_field(reverse_voltage_field),
  .charge_current_limit_eff(charge_current_limit_eff),
  .input_current_limit_eff(input_current_limit_eff));
